/* File: logic/tmr_out_pkg.sv */
// Package with register map, field layouts and carriers for the timer output and start control
// Functional notes
// - One output-enable bit per channel; channel 3 at bit 3, channel 0 at bit 0.
// - Output-enable 0: timer activity never updates that channel's output bit.
// - Output-enable 0: software writes to the output bit take effect on the pin.
// - Output-enable 1: timer waveform drives the channel's output bit.
// - Output-enable 1: software writes to that output bit are discarded.
// - Writing 1 to a start-trigger bit sets count-enable; writing 0 does nothing.
// - When counting really starts after count-enable depends on channel operating mode.
// - Port 3 pin 1 latch holds the driven level: 0 low, 1 high.
// - Direction bit 0: pin is an output, output buffer on.
// - Direction bit 1: pin is an input, output buffer off.
// - Each channel's output bit holds the timer output value, 0 or 1.
// - Polarity bit 0 gives active-high output, 1 gives active-low output.
`default_nettype none
package tmr_out_pkg;
    localparam int          NUM_CH        = 4;
    localparam logic [11:0] OFS_OUT_EN    = 12'h000;
    localparam logic [11:0] OFS_OUT_LEVEL = 12'h004;
    localparam logic [11:0] OFS_POLARITY  = 12'h008;
    localparam logic [11:0] OFS_START     = 12'h00C;
    localparam logic [11:0] OFS_CNT_EN    = 12'h010;
    localparam logic [11:0] OFS_P3_LATCH  = 12'h014;
    localparam logic [11:0] OFS_P3_DIR    = 12'h018;
    localparam logic [11:0] OFS_P3_PINS   = 12'h01C;
    localparam logic [11:0] OFS_CH_MODE   = 12'h020;
    localparam int          P3_PIN1_BIT   = 1;
    localparam logic [15:0] OUT_EN_RST    = 16'h0000;
    localparam logic [15:0] OUT_LEVEL_RST = 16'h0000;
    localparam logic [15:0] POLARITY_RST  = 16'h0000;
    localparam logic [7:0]  P3_LATCH_RST  = 8'h00;
    localparam logic [7:0]  P3_DIR_RST    = 8'hFF;
    localparam logic [15:0] CH_MODE_RST   = 16'h0000;
    localparam int          MODE_W        = 2;

    // Count start behaviour per channel, two bits each in the mode register
    typedef enum logic [1:0] {
        START_IMMEDIATE = 2'h0,
        START_ON_EVENT  = 2'h1,
        START_HELD      = 2'h2,
        START_RSVD      = 2'h3
    } start_mode_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;
endpackage
`default_nettype wire

/* File: logic/tmr_out_ctrl.sv */
// Timer output enable, start trigger and port 3 pin control with an APB register slave
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module tmr_out_ctrl #(
    parameter int NCH = 4
) (
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire tmr_out_pkg::apb_req_t   apb_req,
    output tmr_out_pkg::apb_rsp_t        apb_rsp,
    input  wire logic [NCH-1:0]          timer_wave,
    input  wire logic [NCH-1:0]          count_event,
    input  wire logic [NCH-1:0]          count_stop,
    output logic      [NCH-1:0]          count_enabled,
    output logic      [NCH-1:0]          counting,
    output logic      [NCH-1:0]          timer_pin,
    input  wire logic                    port3_pin1_in,
    output logic                         port3_pin1_out,
    output logic                         port3_pin1_oe
);
    import tmr_out_pkg::*;

    // Mode field and pin status layout leave room for eight channels at most
    if (NCH < 1 || NCH > 8) begin : bad_nch
        $error("NCH must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [NCH-1:0]        out_en_q;
    logic [NCH-1:0]        out_level_q;
    logic [NCH-1:0]        out_level_d;
    logic [NCH-1:0]        polarity_q;
    logic [NCH-1:0]        cnt_en_q;
    logic [NCH-1:0]        cnt_en_d;
    logic [NCH-1:0]        run_q;
    logic [NCH-1:0]        run_d;
    logic [2*NCH-1:0]      mode_q;
    logic [7:0]            p3_latch_q;
    logic [7:0]            p3_dir_q;
    logic                  pin_meta_q;
    logic                  pin_sync_q;
    logic [NCH-1:0]        pin_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode; every access completes in its first access cycle
    wire        acc      = apb_req.psel & apb_req.penable;
    wire        wr       = acc & apb_req.pwrite;
    wire        lane0    = apb_req.pstrb[0];
    wire        lane1    = apb_req.pstrb[1];
    wire        hit_oe   = apb_req.paddr == OFS_OUT_EN;
    wire        hit_lvl  = apb_req.paddr == OFS_OUT_LEVEL;
    wire        hit_pol  = apb_req.paddr == OFS_POLARITY;
    wire        hit_st   = apb_req.paddr == OFS_START;
    wire        hit_ce   = apb_req.paddr == OFS_CNT_EN;
    wire        hit_lat  = apb_req.paddr == OFS_P3_LATCH;
    wire        hit_dir  = apb_req.paddr == OFS_P3_DIR;
    wire        hit_pins = apb_req.paddr == OFS_P3_PINS;
    wire        hit_mode = apb_req.paddr == OFS_CH_MODE;
    wire        mapped   = hit_oe | hit_lvl | hit_pol | hit_st | hit_ce | hit_lat | hit_dir
                         | hit_pins | hit_mode;
    wire [NCH-1:0] wdat  = apb_req.pwdata[NCH-1:0];
    wire        wr_oe    = wr & hit_oe & lane0;
    wire        wr_lvl   = wr & hit_lvl & lane0;
    wire        wr_pol   = wr & hit_pol & lane0;
    wire        wr_lat   = wr & hit_lat & lane0;
    wire        wr_dir   = wr & hit_dir & lane0;
    wire        wr_mode  = wr & hit_mode & (lane0 | lane1);
    wire [NCH-1:0] start_pulse = (wr & hit_st & lane0) ? wdat : '0;

    function automatic logic [31:0] zext(input logic [15:0] v);
        zext = {16'h0000, v};
    endfunction

    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (hit_oe) begin
            rd_val[NCH-1:0] = out_en_q;
        end else if (hit_lvl) begin
            rd_val[NCH-1:0] = out_level_q;
        end else if (hit_pol) begin
            rd_val[NCH-1:0] = polarity_q;
        end else if (hit_ce) begin
            rd_val[NCH-1:0] = cnt_en_q;
        end else if (hit_lat) begin
            rd_val[7:0] = p3_latch_q;
        end else if (hit_dir) begin
            rd_val[7:0] = p3_dir_q;
        end else if (hit_pins) begin
            rd_val[NCH-1:0] = pin_q;
            rd_val[8 + P3_PIN1_BIT] = pin_sync_q;
        end else if (hit_mode) begin
            rd_val[2*NCH-1:0] = mode_q;
        end
    end

    logic [31:0] prdata_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
            prdata_q <= zext(rd_val);
        end
    end

    assign apb_rsp = '{pready: 1'b1, pslverr: acc & ~mapped, prdata: prdata_q};

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_en_q   <= OUT_EN_RST[NCH-1:0];
            polarity_q <= POLARITY_RST[NCH-1:0];
            p3_latch_q <= P3_LATCH_RST;
            p3_dir_q   <= P3_DIR_RST;
            mode_q     <= CH_MODE_RST[2*NCH-1:0];
        end else begin
            if (wr_oe) out_en_q <= wdat;
            if (wr_pol) polarity_q <= wdat;
            if (wr_lat) p3_latch_q <= apb_req.pwdata[7:0];
            if (wr_dir) p3_dir_q <= apb_req.pwdata[7:0];
            if (wr_mode) mode_q <= apb_req.pwdata[2*NCH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output bits: timer owns enabled channels, software owns the rest
    always_comb begin
        out_level_d = out_level_q;
        for (int i = 0; i < NCH; i++) begin
            if (out_en_q[i]) begin
                out_level_d[i] = timer_wave[i];
            end else if (wr_lvl) begin
                out_level_d[i] = wdat[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Count enable and start gating; a start wins over a simultaneous stop
    always_comb begin
        cnt_en_d = (cnt_en_q & ~count_stop) | start_pulse;
        run_d    = run_q & cnt_en_d;
        for (int i = 0; i < NCH; i++) begin
            unique case (start_mode_t'(mode_q[2*i +: MODE_W]))
                START_IMMEDIATE: if (start_pulse[i]) run_d[i] = 1'b1;
                START_ON_EVENT:  if (cnt_en_d[i] & count_event[i]) run_d[i] = 1'b1;
                START_HELD:      run_d[i] = 1'b0;
                START_RSVD:      run_d[i] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            out_level_q <= OUT_LEVEL_RST[NCH-1:0];
            cnt_en_q    <= '0;
            run_q       <= '0;
            pin_q       <= '0;
        end else begin
            out_level_q <= out_level_d;
            cnt_en_q    <= cnt_en_d;
            run_q       <= run_d;
            pin_q       <= out_level_d ^ polarity_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port 3 pin 1 buffer and input synchroniser
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= port3_pin1_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign count_enabled  = cnt_en_q;
    assign counting       = run_q;
    assign timer_pin      = pin_q;
    assign port3_pin1_out = p3_latch_q[P3_PIN1_BIT];
    assign port3_pin1_oe  = ~p3_dir_q[P3_PIN1_BIT];
endmodule
`default_nettype wire

/* File: test/tmr_out_ctrl_sva.sv */
// Checker for the timer output and start control ports
`timescale 1ns/1ns
`default_nettype none
module tmr_out_ctrl_sva #(parameter int NCH = 4) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire tmr_out_pkg::apb_req_t apb_req,
    input wire tmr_out_pkg::apb_rsp_t apb_rsp,
    input wire logic [NCH-1:0]        timer_wave,
    input wire logic [NCH-1:0]        count_event,
    input wire logic [NCH-1:0]        count_stop,
    input wire logic [NCH-1:0]        count_enabled,
    input wire logic [NCH-1:0]        counting,
    input wire logic [NCH-1:0]        timer_pin,
    input wire logic                  port3_pin1_in,
    input wire logic                  port3_pin1_out,
    input wire logic                  port3_pin1_oe
);
    import tmr_out_pkg::*;
    logic [NCH-1:0] en_q;
    logic [NCH-1:0] pol_q;
    wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
        && apb_req.pstrb[0];
    wire logic [NCH-1:0] wd = apb_req.pwdata[NCH-1:0];
    wire logic lw = wr && apb_req.paddr == OFS_OUT_LEVEL;
    wire logic pw = wr && apb_req.paddr == OFS_POLARITY;
    wire logic [NCH-1:0] st = (wr && apb_req.paddr == OFS_START) ? wd : '0;
    // Shadow copies of output enable and polarity
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            en_q <= '0;
            pol_q <= '0;
        end else begin
            if (wr && apb_req.paddr == OFS_OUT_EN) en_q <= wd;
            if (pw) pol_q <= wd;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    dir_oe_a: assert property (wr && apb_req.paddr == OFS_P3_DIR
        |=> port3_pin1_oe == !$past(apb_req.pwdata[1])) else $error("pin enable wrong");
    latch_out_a: assert property (wr && apb_req.paddr == OFS_P3_LATCH
        |=> port3_pin1_out == $past(apb_req.pwdata[1])) else $error("pin level wrong");
    start_set_a: assert property (st != '0 |=> (count_enabled & $past(st)) == $past(st))
        else $error("start did not enable");
    start_only_a: assert property (((count_enabled & ~$past(count_enabled)) & ~$past(st)) == '0)
        else $error("enable rose without start");
    count_gate_a: assert property ((counting & ~count_enabled) == '0)
        else $error("counting while disabled");
    wave_drive_a: assert property (((timer_pin ^ $past(timer_wave) ^ $past(pol_q)) & $past(en_q)) == '0)
        else $error("pin not following wave");
    level_hold_a: assert property (!$past(lw) && !$past(pw) && !$past(pw, 2)
        |-> ((timer_pin ^ $past(timer_pin)) & ~$past(en_q)) == '0) else $error("pin moved");
    level_write_a: assert property (lw |=> ((timer_pin ^ $past(wd) ^ pol_q) & ~$past(en_q)) == '0)
        else $error("level write lost");
endmodule
`default_nettype wire

/* File: test/tb_tmr_out_ctrl.sv */
// Self-checking bench for the timer output and start control
`timescale 1ns/1ns
`default_nettype none
module tb_tmr_out_ctrl;
    import tmr_out_pkg::*;
    logic       clk_sys, nrst, pin_in, oe, pout, err;
    apb_req_t   req;
    apb_rsp_t   rsp;
    logic [3:0] wave, ev, stp, cen, cnt, pin;
    logic [31:0] rd;
    int         n_fail, samples_checked, cyc;
    tmr_out_ctrl #(.NCH(4)) i_tmr_out_ctrl (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req),
        .apb_rsp(rsp), .timer_wave(wave), .count_event(ev), .count_stop(stp),
        .count_enabled(cen), .counting(cnt), .timer_pin(pin), .port3_pin1_in(pin_in),
        .port3_pin1_out(pout), .port3_pin1_oe(oe));
    task automatic give_verdict;
        $display("checks %0d, failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d, pstrb:4'hF};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        @(posedge clk_sys);
        while (rsp.pready !== 1'b1) @(posedge clk_sys);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask
    task automatic later;
        @(posedge clk_sys);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        xfer(0, OFS_OUT_EN, 0); chk(rd, 0);
        xfer(0, OFS_P3_DIR, 0); chk(rd, 32'h0000_00FF);
        chk(oe, 0);
        xfer(0, 12'hFF0, 0); chk(err, 1); chk(rd, 0);
    endtask
    task automatic t_port;
        xfer(1, OFS_P3_DIR, 32'hFD); later; chk(oe, 1);
        xfer(1, OFS_P3_LATCH, 32'h02); later; chk(pout, 1);
        xfer(1, OFS_P3_LATCH, 32'h00); later; chk(pout, 0);
        xfer(1, OFS_P3_DIR, 32'hFF); later; chk(oe, 0);
        @(posedge clk_sys) pin_in <= 1'b1;
        later; later; xfer(0, OFS_P3_PINS, 0); chk(rd, 32'h0000_0200);
    endtask
    task automatic t_out;
        @(posedge clk_sys) wave <= 4'hF;
        xfer(1, OFS_OUT_LEVEL, 32'h9); later; chk(pin, 4'h9);
        @(posedge clk_sys) wave <= 4'h0;
        later; later; chk(pin, 4'h9);
        xfer(1, OFS_POLARITY, 32'h8); later; chk(pin, 4'h1);
        xfer(1, OFS_OUT_EN, 32'h9);
        @(posedge clk_sys) wave <= 4'h9;
        later; later; chk(pin, 4'h1);
        xfer(1, OFS_OUT_LEVEL, 32'h0); #1; chk(pin, 4'h1);
        later; chk(pin, 4'h1);
        @(posedge clk_sys) wave <= 4'h0;
        later; later; chk(pin, 4'h8);
    endtask
    task automatic t_start;
        xfer(1, OFS_START, 32'h9); later; chk({cen, cnt}, 8'h99);
        xfer(0, OFS_START, 0); chk(rd, 0);
        xfer(1, OFS_START, 32'h0); later; chk(cen, 4'h9);
        @(posedge clk_sys) stp <= 4'h9;
        @(posedge clk_sys) stp <= 4'h0;
        later; later; chk({cen, cnt}, 8'h00);
        xfer(1, OFS_CH_MODE, 32'h1);
        xfer(1, OFS_START, 32'h1); later; chk({cen, cnt}, 8'h10);
        @(posedge clk_sys) ev <= 4'h1;
        @(posedge clk_sys) ev <= 4'h0;
        later; chk(cnt, 4'h1);
        xfer(1, OFS_CH_MODE, 32'h8D);
        xfer(1, OFS_START, 32'hA); later; chk({cen, cnt}, 8'hB1);
        @(posedge clk_sys) ev <= 4'hA;
        @(posedge clk_sys) ev <= 4'h0;
        later; chk(cnt, 4'h1);
        xfer(0, OFS_CNT_EN, 0); chk(rd, 32'h0000_000B);
    endtask
    task automatic t_rerun;
        @(posedge clk_sys) nrst <= 1'b0;
        @(posedge clk_sys) nrst <= 1'b1;
        later; chk({cen, cnt}, 8'h00);
        chk({pin, oe, pout}, 6'h00);
        xfer(0, OFS_OUT_EN, 0); chk(rd, 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict;
        end
    end
    initial begin
        nrst = 1'b0;
        req = '0;
        {wave, ev, stp, pin_in} = '0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset;
        t_port;
        t_out;
        t_start;
        t_rerun;
        give_verdict;
    end
endmodule
bind tmr_out_ctrl tmr_out_ctrl_sva #(.NCH(NCH)) i_tmr_out_ctrl_sva (.clk_sys(clk_sys),
    .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp), .timer_wave(timer_wave),
    .count_event(count_event), .count_stop(count_stop), .count_enabled(count_enabled),
    .counting(counting), .timer_pin(timer_pin), .port3_pin1_in(port3_pin1_in),
    .port3_pin1_out(port3_pin1_out), .port3_pin1_oe(port3_pin1_oe));
`default_nettype wire
